// [hw/adc_cfg_host.v]
// APB-controlled serial programming host for the ADC configuration port
`timescale 1ns/1ps
`include "adc_cfg_map.vh"

module adc_cfg_host (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output reg         serial_select_n,
  output reg         sclk_out,
  output reg         sdio_out,
  output reg         sdio_oe,
  input  wire        sdio_in,
  output reg         device_reset
);

  // ************************************************************
  // States
  // ************************************************************
  localparam [4:0] S_IDLE = 5'b00001;
  localparam [4:0] S_LEAD = 5'b00010;
  localparam [4:0] S_LOW  = 5'b00100;
  localparam [4:0] S_HIGH = 5'b01000;
  localparam [4:0] S_TAIL = 5'b10000;

  // ************************************************************
  // Registers
  // ************************************************************
  reg  [8:0]             ctrl_q;
  reg  [`ADDR_W-1:0]     addr_q;
  reg  [31:0]            wdata_q;
  wire [31:0]            rdata_q;
  reg  [7:0]             div_q;
  reg                    done_q;
  reg  [4:0]             state_q;
  reg  [7:0]             tmr_q;
  reg  [5:0]             bit_q;
  reg  [5:0]             last_q;
  reg                    sin_meta_q;
  reg                    sin_q;
  reg                    start_q;

  wire                   busy;
  wire                   wr_acc;
  wire                   wr_idle;
  wire                   wr_ctrl;
  wire                   wr_addr;
  wire                   wr_wdata;
  wire                   wr_div;
  wire                   rd_setup;
  wire                   tmr_done;
  wire                   in_data;
  wire                   cap_en;
  wire [4:0]             cap_idx;
  wire [5:0]             dbit;
  wire [5:0]             last_bit;
  reg  [31:0]            prdata_d;
  wire [1:0]             len_code;
  wire [15:0]            instr;
  wire                   addr_ok;
  wire                   lsb;
  wire                   is_read;

  assign busy     = (state_q != S_IDLE);

  // ************************************************************
  // APB decode
  // ************************************************************
  assign wr_acc   = psel & penable & pwrite;
  assign wr_idle  = wr_acc & ~busy;
  assign wr_ctrl  = wr_acc & (paddr == `HOST_CTRL_OFS);
  assign wr_addr  = wr_idle & (paddr == `HOST_ADDR_OFS);
  assign wr_wdata = wr_idle & (paddr == `HOST_WDATA_OFS);
  assign wr_div   = wr_acc & (paddr == `HOST_DIV_OFS);
  assign rd_setup = psel & ~penable & ~pwrite;
  // Zero wait states: every access completes in its first access cycle
  assign pready   = 1'b1;
  assign addr_ok  = (paddr == `HOST_CTRL_OFS) | (paddr == `HOST_ADDR_OFS) |
                    (paddr == `HOST_WDATA_OFS) | (paddr == `HOST_RDATA_OFS) |
                    (paddr == `HOST_STATUS_OFS) | (paddr == `HOST_DIV_OFS);
  assign pslverr  = psel & penable & ~addr_ok;
  assign tmr_done = (tmr_q == 8'h00);
  assign lsb      = ctrl_q[`CTRL_LSB_BIT];
  assign is_read  = ctrl_q[`CTRL_READ_BIT];
  assign len_code = {ctrl_q[`CTRL_LEN_HI_BIT], ctrl_q[`CTRL_LEN_LO_BIT]};
  assign instr    = {is_read, len_code, addr_q};

  // ************************************************************
  // Frame bookkeeping
  // ************************************************************
  assign in_data  = (bit_q >= `INSTR_BITS);
  assign dbit     = bit_q - `INSTR_BITS;
  // 16 instruction bits plus 1 to 4 bytes; code 3 must not wrap to 0
  assign last_bit = `INSTR_BITS + `BYTE_BITS - 6'h01 +
                    {1'b0, len_code, 3'h0};
  assign cap_en   = ((state_q == S_LEAD) | (state_q == S_LOW)) & tmr_done &
                    is_read & in_data;
  assign cap_idx  = lsb ? dbit[4:0] : {dbit[4:3], 3'h7 - dbit[2:0]};

  // ************************************************************
  // Bit selection for the current position
  // ************************************************************
  function tx_bit;
    input [5:0]  idx;
    input [15:0] ins;
    input [31:0] wd;
    input        lsb_first;
    reg   [5:0]  d;
    reg   [3:0]  ii;
    begin
      d  = idx - `INSTR_BITS;
      ii = idx[3:0];
      if (idx < `INSTR_BITS) begin
        tx_bit = lsb_first ? ins[ii] : ins[4'hF - ii];
      end else begin
        tx_bit = lsb_first ? wd[{d[4:3], d[2:0]}] :
                             wd[{d[4:3], 3'h7 - d[2:0]}];
      end
    end
  endfunction

  // ************************************************************
  // Data pin synchroniser
  // ************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sin_meta_q <= 1'b0;
      sin_q      <= 1'b0;
    end else begin
      sin_meta_q <= sdio_in;
      sin_q      <= sin_meta_q;
    end
  end

  // ************************************************************
  // APB register writes
  // ************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= `CTRL_RESET_VAL;
      addr_q  <= {`ADDR_W{1'b0}};
      wdata_q <= 32'h00000000;
      div_q   <= `DIV_RESET_VAL;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if (wr_ctrl) begin
        // Frame settings except the divider are frozen while a frame runs
        if (!busy) begin
          ctrl_q  <= pwdata[8:0];
          start_q <= pwdata[`CTRL_START_BIT] & ~pwdata[`CTRL_STRAP_BIT];
        end else begin
          ctrl_q[`CTRL_RESET_BIT] <= pwdata[`CTRL_RESET_BIT];
        end
      end
      if (wr_addr) begin
        addr_q <= pwdata[`ADDR_W-1:0];
      end
      // Software must clear unused bits itself
      if (wr_wdata) begin
        wdata_q <= pwdata;
      end
      if (wr_div) begin
        // Floor keeps the read sample clear of the sync delay
        div_q <= (pwdata[7:0] < `DIV_MIN_VAL) ? `DIV_MIN_VAL : pwdata[7:0];
      end
    end
  end

  // ************************************************************
  // APB read mux
  // ************************************************************
  always @* begin
    case (paddr)
      `HOST_CTRL_OFS:   prdata_d = {23'h000000, ctrl_q};
      `HOST_ADDR_OFS:   prdata_d = {19'h00000, addr_q};
      `HOST_WDATA_OFS:  prdata_d = wdata_q;
      `HOST_RDATA_OFS:  prdata_d = rdata_q;
      `HOST_STATUS_OFS: prdata_d = {30'h00000000, done_q, busy};
      `HOST_DIV_OFS:    prdata_d = {24'h000000, div_q};
      default:          prdata_d = 32'h00000000;
    endcase
  end

  // ************************************************************
  // APB read data, taken in the setup cycle
  // ************************************************************
  // Registered so the access phase sees a settled word
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      prdata <= prdata_d;
    end
  end

  // ************************************************************
  // Serial frame engine
  // ************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q         <= S_IDLE;
      tmr_q           <= 8'h00;
      bit_q           <= 6'h00;
      last_q          <= 6'h00;
      done_q          <= 1'b0;
      serial_select_n <= 1'b1;
      sclk_out        <= 1'b0;
      sdio_out        <= 1'b0;
      sdio_oe         <= 1'b0;
      device_reset    <= 1'b0;
    end else begin
      device_reset <= ctrl_q[`CTRL_RESET_BIT];
      if (tmr_q != 8'h00) begin
        tmr_q <= tmr_q - 8'h01;
      end
      case (state_q)
        S_IDLE: begin
          serial_select_n <= 1'b1;
          if (ctrl_q[`CTRL_STRAP_BIT]) begin
            // Static levels for a device run without the port
            sclk_out <= ctrl_q[`CTRL_FMT_BIT];
            sdio_out <= ctrl_q[`CTRL_DUTY_BIT];
            sdio_oe  <= 1'b1;
          end else begin
            sclk_out <= 1'b0;
            sdio_out <= 1'b0;
            sdio_oe  <= 1'b0;
          end
          if (start_q) begin
            done_q          <= 1'b0;
            serial_select_n <= 1'b0;
            sclk_out        <= 1'b0;
            bit_q           <= 6'h00;
            last_q          <= last_bit;
            sdio_out <= tx_bit(6'h00, instr, wdata_q, lsb);
            sdio_oe  <= 1'b1;
            tmr_q    <= div_q - 8'h01;
            state_q  <= S_LEAD;
          end
        end
        S_LEAD, S_LOW: begin
          if (tmr_done) begin
            sclk_out <= 1'b1;
            tmr_q    <= div_q - 8'h01;
            state_q  <= S_HIGH;
          end
        end
        S_HIGH: begin
          if (tmr_done) begin
            sclk_out <= 1'b0;
            tmr_q    <= div_q - 8'h01;
            if (bit_q == last_q) begin
              sdio_oe <= 1'b0;
              state_q <= S_TAIL;
            end else begin
              bit_q    <= bit_q + 6'h01;
              sdio_out <= tx_bit(bit_q + 6'h01, instr, wdata_q, lsb);
              // Release the pin for the read data phase
              sdio_oe  <= ~(is_read &&
                            (bit_q + 6'h01 >= `INSTR_BITS));
              state_q  <= S_LOW;
            end
          end
        end
        S_TAIL: begin
          if (tmr_done) begin
            serial_select_n <= 1'b1;
            done_q          <= 1'b1;
            state_q         <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Receive word, one flop per bit
  // ************************************************************
  // Device drives since the last falling edge; sample at the rise
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_rx
      reg cell_q;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cell_q <= 1'b0;
        end else if (cap_en && ({27'h0000000, cap_idx} == gi)) begin
          cell_q <= sin_q;
        end
      end
      assign rdata_q[gi] = cell_q;
    end
  endgenerate

endmodule

// [hw/adc_cfg_map.vh]
// Register offsets, fields, reset values and timing for the ADC config host
`ifndef ADC_CFG_MAP_VH
`define ADC_CFG_MAP_VH

// ************************************************************
// Host register map (APB byte addresses)
// ************************************************************
`define HOST_CTRL_OFS      8'h00
`define HOST_ADDR_OFS      8'h04
`define HOST_WDATA_OFS     8'h08
`define HOST_RDATA_OFS     8'h0C
`define HOST_STATUS_OFS    8'h10
`define HOST_DIV_OFS       8'h14

// ************************************************************
// Control register fields
// ************************************************************
`define CTRL_START_BIT     0
`define CTRL_READ_BIT      1
`define CTRL_LSB_BIT       2
`define CTRL_LEN_LO_BIT    3
`define CTRL_LEN_HI_BIT    4
`define CTRL_STRAP_BIT     5
`define CTRL_DUTY_BIT      6
`define CTRL_FMT_BIT       7
`define CTRL_RESET_BIT     8
`define CTRL_RESET_VAL     9'h000

// ************************************************************
// Status fields, divider
// ************************************************************
`define STAT_BUSY_BIT      0
`define STAT_DONE_BIT      1
`define DIV_RESET_VAL      8'h04
`define DIV_MIN_VAL        8'h04

// ************************************************************
// Serial frame layout
// ************************************************************
`define INSTR_BITS         6'h10
`define BYTE_BITS          6'h08
`define ADDR_W             13

// ************************************************************
// Device register space (far end)
// ************************************************************
`define DEV_CHIP_CFG_LO    13'h0000
`define DEV_CHIP_CFG_HI    13'h0002
`define DEV_INDEX_LO       13'h0004
`define DEV_INDEX_HI       13'h0005
`define DEV_TRANSFER       13'h00FF
`define DEV_GLOBAL_LO      13'h0008
`define DEV_GLOBAL_HI      13'h0009
`define DEV_PRODUCT_LO     13'h000B
`define DEV_PRODUCT_HI     13'h0025
`define DEV_CLK_PHASE_OFS  13'h0014
`define DEV_CLK_PHASE_RST  8'h00

`endif

// [verification/adc_cfg_dev.sv]
// Behavioural model of the converter's serial configuration port
`timescale 1ns/1ps
module adc_cfg_dev (
  input wire sel_n,
  input wire sclk,
  input wire sdio,
  input wire lsb,
  input wire rst,
  output reg dout,
  output reg doe
);
  reg [7:0]  mem [0:255];
  reg [15:0] ins;
  reg [7:0]  sh;
  reg [12:0] a;
  reg        duty_on = 0;
  reg        fmt_twos = 0;
  integer    n = 0;
  integer    i;
  // Unlisted places clear too; a real part leaves them undefined
  initial begin
    doe = 0;
    dout = 0;
    for (i = 0; i < 256; i = i + 1) mem[i] = 8'h00;
  end
  always @(posedge rst) begin
    for (i = 0; i < 256; i = i + 1) mem[i] = 8'h00;
    if (sel_n) begin
      duty_on = sdio;
      fmt_twos = sclk;
    end
  end
  always @(negedge sel_n) n = 0;
  always @(posedge sel_n) doe = 0;
  always @(posedge sclk) begin
    if (!sel_n) begin
      if (n < 16) ins[lsb ? n : 15 - n] = sdio;
      else sh[lsb ? (n - 16) % 8 : 7 - (n - 16) % 8] = sdio;
      n = n + 1;
      if (n == 16) a = ins[12:0];
      if (n > 16 && n % 8 == 0) begin
        if (!ins[15]) mem[a[7:0]] = sh;
        a = a + 1;
      end
    end
  end
  always @(negedge sclk) begin
    if (!sel_n && ins[15] && n >= 16) begin
      doe = 1;
      dout = mem[a[7:0]][lsb ? (n - 16) % 8 : 7 - (n - 16) % 8];
    end
  end
endmodule

// [verification/adc_cfg_host_props.sv]
// Port assertions for the ADC configuration host
`timescale 1ns/1ps
module adc_cfg_host_props (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        serial_select_n,
  input wire        sclk_out,
  input wire        sdio_out,
  input wire        sdio_oe,
  input wire        sdio_in,
  input wire        device_reset
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ************
  // Serial timing, device reset copy and APB error answer
  // ************
  // Half periods assume the reset divider of four
  sequence low_half;
    !sclk_out [*4];
  endsequence
  sequence high_half;
    sclk_out [*4] ##1 !sclk_out;
  endsequence
  frame_open_a: assert property ($fell(serial_select_n) |->
    !sclk_out && sdio_oe) else $error("frame opened badly");
  first_rise_a: assert property ($fell(serial_select_n) |->
    low_half ##1 high_half) else $error("first clock rise late");
  high_time_a: assert property ($rose(sclk_out) &&
    !serial_select_n |-> high_half) else $error("clock high time");
  data_hold_a: assert property ($rose(sclk_out) && sdio_oe &&
    !serial_select_n |-> $stable(sdio_out)) else $error("data moved");
  data_move_a: assert property (!serial_select_n &&
    !$past(serial_select_n) && $changed(sdio_out) |-> $fell(sclk_out))
    else $error("data changed off falling edge");
  release_a: assert property ($rose(serial_select_n) |->
    !sdio_oe) else $error("data pin still driven");
  dev_reset_a: assert property (psel && penable && pwrite &&
    paddr == 8'h00 |-> ##2 device_reset == $past(pwdata[8], 2))
    else $error("device reset not copied");
  apb_answer_a: assert property (psel && penable && paddr > 8'h14
    |-> pready && pslverr) else $error("unmapped access accepted");
endmodule

// [verification/tb_adc_cfg_host.sv]
// Self-checking bench for the ADC configuration host
`timescale 1ns/1ps
`include "adc_cfg_map.vh"
`define CHK(s, e, g) begin n_checks++; if ((g) !== (e)) begin \
  miscompares++; $display("[FAIL] %s exp %h got %h", s, e, g); end end
module tb_adc_cfg_host;
  reg         pclk = 0;
  reg         presetn = 0;
  reg         psel = 0;
  reg         penable = 0;
  reg         pwrite = 0;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h0;
  reg  [31:0] rd;
  reg         er;
  reg         lsb_m = 0;
  wire [31:0] prdata;
  wire        pready, pslverr, sel_n, sclk, sdo, soe, dev_rst;
  wire        dout, doe;
  // Pull-up holds the released data line high
  wire        sdio_w = soe ? sdo : (doe ? dout : 1'b1);
  int         miscompares = 0;
  int         n_checks = 0;
  always #4 pclk = ~pclk;
  adc_cfg_host u_adc_cfg_host (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_select_n(sel_n), .sclk_out(sclk),
    .sdio_out(sdo), .sdio_oe(soe), .sdio_in(sdio_w),
    .device_reset(dev_rst));
  adc_cfg_dev u_adc_cfg_dev (.sel_n(sel_n), .sclk(sclk), .sdio(sdio_w),
    .lsb(lsb_m), .rst(dev_rst), .dout(dout), .doe(doe));
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    int k;
    begin
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      k = 0;
      do begin @(posedge pclk); k++; end
        while (pready !== 1'b1 && k < 50);
      if (pready !== 1'b1) begin miscompares++; end_sim; end
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
    end
  endtask
  // Runs one frame and always ends with a read of the receive word
  task frame(input [8:0] c, input [12:0] a, input [31:0] d);
    int k;
    begin
      apb(1, `HOST_ADDR_OFS, {19'h0, a});
      apb(1, `HOST_WDATA_OFS, d);
      apb(1, `HOST_CTRL_OFS, {23'h0, c} | 32'h1);
      k = 0;
      do begin apb(0, `HOST_STATUS_OFS, 0); k++; end
        while (rd[1] !== 1'b1 && k < 2000);
      if (rd[1] !== 1'b1) begin miscompares++; end_sim; end
      apb(0, `HOST_RDATA_OFS, 0);
    end
  endtask
  task t_reset;
    begin
      `CHK("sel_n", 1'b1, sel_n)
      apb(0, `HOST_CTRL_OFS, 0);
      `CHK("ctrl", 32'h0, rd)
      frame(9'h002, `DEV_CLK_PHASE_OFS, 0);
      `CHK("phase", `DEV_CLK_PHASE_RST, rd[7:0])
    end
  endtask
  task t_msb;
    begin
      frame(9'h008, 13'h0014, 32'h0000A53C);
      `CHK("wr0", 8'h3C, u_adc_cfg_dev.mem[20])
      `CHK("wr1", 8'hA5, u_adc_cfg_dev.mem[21])
      `CHK("bits", 32, u_adc_cfg_dev.n)
      frame(9'h00A, 13'h0014, 0);
      `CHK("rd", 16'hA53C, rd[15:0])
    end
  endtask
  task t_lsb;
    begin
      lsb_m = 1;
      frame(9'h01C, 13'h0020, 32'h8421C3E1);
      `CHK("lsb0", 8'hE1, u_adc_cfg_dev.mem[32])
      `CHK("lsb3", 8'h84, u_adc_cfg_dev.mem[35])
      `CHK("bits4", 48, u_adc_cfg_dev.n)
      frame(9'h01E, 13'h0020, 0);
      `CHK("lsbrd", 32'h8421C3E1, rd)
      lsb_m = 0;
    end
  endtask
  task t_err;
    begin
      apb(0, 8'h18, 0);
      `CHK("slverr", 1'b1, er)
      `CHK("unmapped", 32'h0, rd)
      apb(1, `HOST_DIV_OFS, 2);
      apb(0, `HOST_DIV_OFS, 0);
      `CHK("div", 32'h4, rd)
    end
  endtask
  task t_strap;
    begin
      apb(1, `HOST_CTRL_OFS, 32'hA1);
      apb(0, `HOST_STATUS_OFS, 0);
      `CHK("busy", 1'b0, rd[0])
      `CHK("strap_sel", 1'b1, sel_n)
      `CHK("fmt_hi", 1'b1, sclk)
      `CHK("duty_lo", 1'b0, sdo)
      apb(1, `HOST_CTRL_OFS, 32'h1A1);
      apb(1, `HOST_CTRL_OFS, 32'hA0);
      `CHK("lat_fmt1", 1'b1, u_adc_cfg_dev.fmt_twos)
      `CHK("lat_duty0", 1'b0, u_adc_cfg_dev.duty_on)
      apb(1, `HOST_CTRL_OFS, 32'h60);
      apb(0, `HOST_STATUS_OFS, 0);
      `CHK("fmt_lo", 1'b0, sclk)
      `CHK("duty_hi", 1'b1, sdo)
      apb(1, `HOST_CTRL_OFS, 32'h160);
      apb(1, `HOST_CTRL_OFS, 32'h60);
      `CHK("lat_fmt0", 1'b0, u_adc_cfg_dev.fmt_twos)
      `CHK("lat_duty1", 1'b1, u_adc_cfg_dev.duty_on)
      apb(1, `HOST_CTRL_OFS, 0);
    end
  endtask
  task t_devrst;
    begin
      apb(1, `HOST_CTRL_OFS, 32'h100);
      repeat (3) @(posedge pclk);
      `CHK("dev_rst", 1'b1, dev_rst)
      apb(1, `HOST_CTRL_OFS, 0);
      frame(9'h002, 13'h0014, 0);
      `CHK("phase_rst", 8'h00, rd[7:0])
    end
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    t_reset;
    t_msb;
    t_lsb;
    t_err;
    t_strap;
    t_devrst;
    end_sim;
  end
endmodule
bind adc_cfg_host adc_cfg_host_props u_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .serial_select_n(serial_select_n),
  .sclk_out(sclk_out), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
  .sdio_in(sdio_in), .device_reset(device_reset));
